// ### modulo_bitrev_pkg.sv
// Shared constants, types and helpers for the address correction logic
package modulo_bitrev_pkg;

  // ****************************************************************
  // Register map, byte addresses on the register bus
  // ****************************************************************
  localparam logic [7:0] MODULO_CONTROL_ADDR      = 8'h00;
  localparam logic [7:0] X_MODULO_START_ADDR      = 8'h04;
  localparam logic [7:0] X_MODULO_END_ADDR        = 8'h08;
  localparam logic [7:0] Y_MODULO_START_ADDR      = 8'h0c;
  localparam logic [7:0] Y_MODULO_END_ADDR        = 8'h10;
  localparam logic [7:0] BIT_REVERSE_CONTROL_ADDR = 8'h14;
  localparam logic [7:0] LAST_ADDRESS_STATUS_ADDR = 8'h18;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int X_MODULO_EN_BIT      = 15;
  localparam int Y_MODULO_EN_BIT      = 14;
  localparam int REV_PTR_LSB          = 8;
  localparam int Y_MOD_PTR_LSB        = 4;
  localparam int X_MOD_PTR_LSB        = 0;
  localparam int BIT_REVERSE_EN_BIT   = 15;
  localparam int STAT_BITREV_BIT      = 15;
  localparam int STAT_MODULO_BIT      = 14;

  localparam logic [15:0] MODULO_CONTROL_RESET      = 16'h0fff;
  localparam logic [15:0] BOUNDARY_RESET            = 16'h0000;
  localparam logic [15:0] BIT_REVERSE_CONTROL_RESET = 16'h0000;

  // Pointer select value that names the stack pointer, never usable here
  localparam logic [3:0]  POINTER_NONE = 4'hf;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    mode_indirect,
    mode_post_dec,
    mode_post_inc,
    mode_pre_dec,
    mode_pre_inc,
    mode_offset
  } addr_mode_e;

  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        byte_access;
    addr_mode_e  mode;
    logic [3:0]  wsel;
    logic [15:0] pointer;
    logic [15:0] offset;
  } agu_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        writeback;
    logic [3:0]  wsel;
    logic [15:0] wb_value;
    logic        bitrev_used;
    logic        modulo_used;
  } agu_rsp_s;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] bitrev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15 - i];
    return r;
  endfunction

  // Byte-lane merge of a 16-bit register from a 32-bit bus word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = wdata[7:0];
    if (sel[1])
      r[15:8] = wdata[15:8];
    return r;
  endfunction

endpackage

// ### modulo_corrector.sv
// Circular buffer boundary correction for one address generator
`timescale 1ns/1ps
module modulo_corrector
(
  input  logic        enable,
  input  logic        incrementing,
  input  logic [15:0] addr,
  input  logic [15:0] start_addr,
  input  logic [15:0] end_addr,
  output logic [15:0] corrected,
  output logic        wrapped
);

  logic [15:0] length;

  // Inclusive bounds, so the buffer spans end - start + 1 bytes
  assign length = 16'(end_addr - start_addr + 16'h0001);

  always_comb
  begin
    corrected = addr;
    wrapped   = 1'b0;
    if (enable)
    begin
      // Magnitude tests, so a step that overshoots is still folded back
      if (incrementing && (addr > end_addr))
      begin
        corrected = 16'(addr - length);
        wrapped   = 1'b1;
      end
      else if (!incrementing && (addr < start_addr))
      begin
        corrected = 16'(addr + length);
        wrapped   = 1'b1;
      end
    end
  end

endmodule

// ### bitrev_adder.sv
// Reverse-carry addition of a pointer and the pivot modifier
`timescale 1ns/1ps
module bitrev_adder
(
  input  logic [15:0] pointer,
  input  logic [14:0] pivot,
  output logic [15:0] sum
);

  logic [15:0] modifier;
  logic [15:0] rev_sum;
  logic [15:0] norm_sum;

  // Pivot counts words, so it is scaled to a byte modifier
  assign modifier = {pivot, 1'b0};
  // Only the carry path runs reversed; pointer keeps normal order
  assign rev_sum  = 16'(modulo_bitrev_pkg::bitrev16(pointer)
                      + modulo_bitrev_pkg::bitrev16(modifier));
  // Word data only: the low address bit is always clear
  assign norm_sum = modulo_bitrev_pkg::bitrev16(rev_sum);
  assign sum      = {norm_sum[15:1], 1'b0};

endmodule

// ### modulo_bitrev_address_gen.sv
// Modulo effective address correction for the X and Y generators, bit-reversed for the X generator only
`timescale 1ns/1ps
// How it works
// - Modulo applies to any working register pointer; here select 1111 turns it off
// - Wrap on greater or less, not equality
// - Write back corrected pointer only for modify modes
// - Offset form corrected, pointer left unchanged
// - Bit reverse only on X generator writes
// - Only the modifier is bit reversed
// - Needs select not 1111, enable, pre/post increment
// - Pivot modifier held in control bits 14:0
// - Bit reversed address low bit forced zero
// - Byte or other modes give ordinary address
// - Bit reverse adds pivot, ignores normal increment
// - Bit reverse wins over modulo on writes
module modulo_bitrev_address_gen
(
  input  logic                         mclk,
  input  logic                         rst,
  input  logic                         wb_cyc_i,
  input  logic                         wb_stb_i,
  input  logic                         wb_we_i,
  input  logic [7:0]                   wb_adr_i,
  input  logic [3:0]                   wb_sel_i,
  input  logic [31:0]                  wb_dat_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  input  modulo_bitrev_pkg::agu_req_s  x_req,
  input  modulo_bitrev_pkg::agu_req_s  y_req,
  output modulo_bitrev_pkg::agu_rsp_s  x_rsp,
  output modulo_bitrev_pkg::agu_rsp_s  y_rsp
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [15:0] modulo_control;
  logic [15:0] mod_start [2];
  logic [15:0] mod_end   [2];
  logic [15:0] bit_reverse_control;
  logic [15:0] last_address_status;

  logic                        bus_req;
  logic                        bus_write;
  logic [31:0]                 next_rdata;

  modulo_bitrev_pkg::agu_req_s req     [2];
  logic [15:0]                 ea_norm [2];
  logic [15:0]                 wbv_norm[2];
  logic                        wbe_norm[2];
  logic                        mod_used[2];
  logic                        pre_form[2];
  logic                        mod_en  [2];
  logic [3:0]                  mod_ptr [2];

  logic [3:0]                  reverse_pointer_select;
  logic                        bit_reverse_enable;
  logic [14:0]                 pivot;
  logic                        brev_active;
  logic [15:0]                 brev_sum;

  modulo_bitrev_pkg::agu_rsp_s next_x_rsp;
  modulo_bitrev_pkg::agu_rsp_s next_y_rsp;

  // Index 0 is the X generator, index 1 the Y generator
  assign req[0] = x_req;
  assign req[1] = y_req;

  // ****************************************************************
  // Control field decode
  // ****************************************************************
  assign mod_en[0] = modulo_control[modulo_bitrev_pkg::X_MODULO_EN_BIT];
  assign mod_en[1] = modulo_control[modulo_bitrev_pkg::Y_MODULO_EN_BIT];
  assign mod_ptr[0] = modulo_control[modulo_bitrev_pkg::X_MOD_PTR_LSB +: 4];
  assign mod_ptr[1] = modulo_control[modulo_bitrev_pkg::Y_MOD_PTR_LSB +: 4];

  assign reverse_pointer_select = modulo_control[modulo_bitrev_pkg::REV_PTR_LSB +: 4];
  assign bit_reverse_enable = bit_reverse_control[modulo_bitrev_pkg::BIT_REVERSE_EN_BIT];
  assign pivot              = bit_reverse_control[14:0];

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // One wait state: ack rises the cycle after the strobe and drops
  // the cycle after, so a held request is not taken again in the ack cycle.
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write = bus_req && wb_we_i;

  always_ff @(posedge mclk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      modulo_bitrev_pkg::MODULO_CONTROL_ADDR:
        next_rdata[15:0] = modulo_control;
      modulo_bitrev_pkg::X_MODULO_START_ADDR:
        next_rdata[15:0] = mod_start[0];
      modulo_bitrev_pkg::X_MODULO_END_ADDR:
        next_rdata[15:0] = mod_end[0];
      modulo_bitrev_pkg::Y_MODULO_START_ADDR:
        next_rdata[15:0] = mod_start[1];
      modulo_bitrev_pkg::Y_MODULO_END_ADDR:
        next_rdata[15:0] = mod_end[1];
      modulo_bitrev_pkg::BIT_REVERSE_CONTROL_ADDR:
        next_rdata[15:0] = bit_reverse_control;
      modulo_bitrev_pkg::LAST_ADDRESS_STATUS_ADDR:
        next_rdata[15:0] = last_address_status;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req && !wb_we_i)
      wb_dat_o <= next_rdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      modulo_control <= modulo_bitrev_pkg::MODULO_CONTROL_RESET;
    else if (bus_write && (wb_adr_i == modulo_bitrev_pkg::MODULO_CONTROL_ADDR))
      modulo_control <= modulo_bitrev_pkg::merge16(modulo_control, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mod_start[0] <= modulo_bitrev_pkg::BOUNDARY_RESET;
      mod_start[1] <= modulo_bitrev_pkg::BOUNDARY_RESET;
      mod_end[0]   <= modulo_bitrev_pkg::BOUNDARY_RESET;
      mod_end[1]   <= modulo_bitrev_pkg::BOUNDARY_RESET;
    end
    else if (bus_write)
    begin
      unique case (wb_adr_i)
        modulo_bitrev_pkg::X_MODULO_START_ADDR:
          mod_start[0] <= modulo_bitrev_pkg::merge16(mod_start[0], wb_dat_i, wb_sel_i);
        modulo_bitrev_pkg::X_MODULO_END_ADDR:
          mod_end[0] <= modulo_bitrev_pkg::merge16(mod_end[0], wb_dat_i, wb_sel_i);
        modulo_bitrev_pkg::Y_MODULO_START_ADDR:
          mod_start[1] <= modulo_bitrev_pkg::merge16(mod_start[1], wb_dat_i, wb_sel_i);
        modulo_bitrev_pkg::Y_MODULO_END_ADDR:
          mod_end[1] <= modulo_bitrev_pkg::merge16(mod_end[1], wb_dat_i, wb_sel_i);
        default:
        begin
        end
      endcase
    end
  end

  // New pivot or enable is seen by the very next request, so the
  // read-after-write hazard software must avoid does not arise here.
  always_ff @(posedge mclk)
  begin
    if (rst)
      bit_reverse_control <= modulo_bitrev_pkg::BIT_REVERSE_CONTROL_RESET;
    else if (bus_write && (wb_adr_i == modulo_bitrev_pkg::BIT_REVERSE_CONTROL_ADDR))
      bit_reverse_control <= modulo_bitrev_pkg::merge16(bit_reverse_control, wb_dat_i,
                                                        wb_sel_i);
  end

  // ****************************************************************
  // Per-generator address formation and modulo correction
  // ****************************************************************
  for (genvar g = 0; g < 2; g++)
  begin : gen_agu
    logic [15:0] step;
    logic [15:0] modified;
    logic        incrementing;
    logic        modify_form;
    logic        hit;
    logic [15:0] corrected;

    always_comb
    begin
      step = req[g].byte_access ? modulo_bitrev_pkg::BYTE_STEP
                                : modulo_bitrev_pkg::WORD_STEP;
      modified     = req[g].pointer;
      incrementing = 1'b1;
      modify_form  = 1'b0;
      pre_form[g]  = 1'b1;
      unique case (req[g].mode)
        modulo_bitrev_pkg::mode_indirect:
        begin
          modified = req[g].pointer;
        end
        modulo_bitrev_pkg::mode_post_inc:
        begin
          modified    = 16'(req[g].pointer + step);
          modify_form = 1'b1;
          pre_form[g] = 1'b0;
        end
        modulo_bitrev_pkg::mode_post_dec:
        begin
          modified     = 16'(req[g].pointer - step);
          incrementing = 1'b0;
          modify_form  = 1'b1;
          pre_form[g]  = 1'b0;
        end
        modulo_bitrev_pkg::mode_pre_inc:
        begin
          modified    = 16'(req[g].pointer + step);
          modify_form = 1'b1;
        end
        modulo_bitrev_pkg::mode_pre_dec:
        begin
          modified     = 16'(req[g].pointer - step);
          incrementing = 1'b0;
          modify_form  = 1'b1;
        end
        modulo_bitrev_pkg::mode_offset:
        begin
          // A negative offset walks the buffer downward
          modified     = 16'(req[g].pointer + req[g].offset);
          incrementing = !req[g].offset[15];
        end
      endcase
    end

    // Any working register but select 1111 may be the circular pointer
    assign hit = mod_en[g] && (mod_ptr[g] != modulo_bitrev_pkg::POINTER_NONE)
                 && (req[g].wsel == mod_ptr[g]);

    modulo_corrector u_modulo
    (
      .enable       (hit),
      .incrementing (incrementing),
      .addr         (modified),
      .start_addr   (mod_start[g]),
      .end_addr     (mod_end[g]),
      .corrected    (corrected),
      .wrapped      ()
    );

    assign ea_norm[g]  = pre_form[g] ? corrected : req[g].pointer;
    assign wbv_norm[g] = corrected;
    assign wbe_norm[g] = modify_form;
    assign mod_used[g] = hit;
  end

  // ****************************************************************
  // Bit-reversed path, X generator only
  // ****************************************************************
  // Byte accesses, reads and other modes fall back to the normal path
  assign brev_active = x_req.valid && x_req.is_write && !x_req.byte_access
                       && ((x_req.mode == modulo_bitrev_pkg::mode_pre_inc)
                           || (x_req.mode == modulo_bitrev_pkg::mode_post_inc))
                       && bit_reverse_enable
                       && (reverse_pointer_select != modulo_bitrev_pkg::POINTER_NONE)
                       && (x_req.wsel == reverse_pointer_select);

  // The pointer is always summed with the pivot; the mode step is unused
  bitrev_adder u_bitrev
  (
    .pointer (x_req.pointer),
    .pivot   (pivot),
    .sum     (brev_sum)
  );

  // ****************************************************************
  // Result select, all combinational ahead of one register stage
  // ****************************************************************
  // Correction and plain address share one cycle, so no stall is added
  always_comb
  begin
    next_x_rsp.valid       = x_req.valid;
    next_x_rsp.wsel        = x_req.wsel;
    next_x_rsp.modulo_used = mod_used[0] && !brev_active;
    next_x_rsp.bitrev_used = brev_active;
    if (brev_active)
    begin
      next_x_rsp.ea        = pre_form[0] ? brev_sum
                                         : {x_req.pointer[15:1], 1'b0};
      next_x_rsp.writeback = 1'b1;
      next_x_rsp.wb_value  = brev_sum;
    end
    else
    begin
      next_x_rsp.ea        = ea_norm[0];
      next_x_rsp.writeback = wbe_norm[0];
      next_x_rsp.wb_value  = wbv_norm[0];
    end
  end

  always_comb
  begin
    next_y_rsp.valid       = y_req.valid;
    next_y_rsp.wsel        = y_req.wsel;
    next_y_rsp.ea          = ea_norm[1];
    next_y_rsp.writeback   = wbe_norm[1];
    next_y_rsp.wb_value    = wbv_norm[1];
    next_y_rsp.modulo_used = mod_used[1];
    next_y_rsp.bitrev_used = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      x_rsp <= '0;
      y_rsp <= '0;
    end
    else
    begin
      x_rsp <= next_x_rsp;
      y_rsp <= next_y_rsp;
      // Writeback only qualifies a valid request
      x_rsp.writeback <= next_x_rsp.writeback && x_req.valid;
      y_rsp.writeback <= next_y_rsp.writeback && y_req.valid;
    end
  end

  // ****************************************************************
  // Status: last X address and how it was formed
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
      last_address_status <= 16'h0000;
    else if (x_req.valid)
    begin
      last_address_status <= next_x_rsp.ea;
      last_address_status[modulo_bitrev_pkg::STAT_BITREV_BIT] <= brev_active;
      last_address_status[modulo_bitrev_pkg::STAT_MODULO_BIT] <= next_x_rsp.modulo_used;
    end
  end

endmodule

// ### modulo_bitrev_address_gen_checker.sv
// Concurrent checks on the ports of the address correction block
`timescale 1ns/1ps
module modulo_bitrev_address_gen_checker
(
  input logic                        mclk,
  input logic                        rst,
  input logic                        wb_cyc_i,
  input logic                        wb_stb_i,
  input logic                        wb_we_i,
  input logic [7:0]                  wb_adr_i,
  input logic [3:0]                  wb_sel_i,
  input logic [31:0]                 wb_dat_i,
  input logic [31:0]                 wb_dat_o,
  input logic                        wb_ack_o,
  input modulo_bitrev_pkg::agu_req_s x_req,
  input modulo_bitrev_pkg::agu_req_s y_req,
  input modulo_bitrev_pkg::agu_rsp_s x_rsp,
  input modulo_bitrev_pkg::agu_rsp_s y_rsp
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("bus request not acked");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_latency; x_req.valid |=> x_rsp.valid; endproperty
  a_latency: assert property (p_latency) else $error("x result late");
  property p_y_idle; !y_req.valid |=> !y_rsp.valid && !y_rsp.writeback; endproperty
  a_y_idle: assert property (p_y_idle) else $error("y result without request");
  property p_y_no_rev; !y_rsp.bitrev_used; endproperty
  a_y_no_rev: assert property (p_y_no_rev) else $error("y generator bit reversed");
  property p_read_no_rev; x_req.valid && !x_req.is_write |=> !x_rsp.bitrev_used; endproperty
  a_read_no_rev: assert property (p_read_no_rev) else $error("read bit reversed");
  property p_byte_no_rev; x_req.valid && x_req.byte_access |=> !x_rsp.bitrev_used; endproperty
  a_byte_no_rev: assert property (p_byte_no_rev) else $error("byte bit reversed");
  property p_mode_no_rev;
    x_req.valid && !(x_req.mode inside {modulo_bitrev_pkg::mode_pre_inc,
      modulo_bitrev_pkg::mode_post_inc}) |=> !x_rsp.bitrev_used;
  endproperty
  a_mode_no_rev: assert property (p_mode_no_rev) else $error("mode bit reversed");
  property p_rev_lsb; x_rsp.bitrev_used |-> !x_rsp.ea[0] && !x_rsp.wb_value[0]; endproperty
  a_rev_lsb: assert property (p_rev_lsb) else $error("reversed address odd");
  property p_no_wb;
    x_req.valid && (x_req.mode inside {modulo_bitrev_pkg::mode_offset,
      modulo_bitrev_pkg::mode_indirect}) |=> !x_rsp.writeback;
  endproperty
  a_no_wb: assert property (p_no_wb) else $error("pointer written back");
  property p_wb;
    x_req.valid && !(x_req.mode inside {modulo_bitrev_pkg::mode_offset,
      modulo_bitrev_pkg::mode_indirect}) |=> x_rsp.writeback && x_rsp.wsel == $past(x_req.wsel);
  endproperty
  a_wb: assert property (p_wb) else $error("modify mode without write back");
  property p_post_ea;
    y_req.valid && y_req.mode == modulo_bitrev_pkg::mode_post_dec
      |=> y_rsp.ea == $past(y_req.pointer);
  endproperty
  a_post_ea: assert property (p_post_ea) else $error("post modify address changed");
endmodule

bind modulo_bitrev_address_gen modulo_bitrev_address_gen_checker u_chk
(
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .x_req(x_req), .y_req(y_req), .x_rsp(x_rsp), .y_rsp(y_rsp)
);

// ### test_modulo_bitrev_address_gen.sv
// Register and address generation tests for the address correction block
`timescale 1ns/1ps
module test_modulo_bitrev_address_gen;
  localparam modulo_bitrev_pkg::addr_mode_e m_ind = modulo_bitrev_pkg::mode_indirect;
  localparam modulo_bitrev_pkg::addr_mode_e m_pod = modulo_bitrev_pkg::mode_post_dec;
  localparam modulo_bitrev_pkg::addr_mode_e m_poi = modulo_bitrev_pkg::mode_post_inc;
  localparam modulo_bitrev_pkg::addr_mode_e m_prd = modulo_bitrev_pkg::mode_pre_dec;
  localparam modulo_bitrev_pkg::addr_mode_e m_pri = modulo_bitrev_pkg::mode_pre_inc;
  localparam modulo_bitrev_pkg::addr_mode_e m_off = modulo_bitrev_pkg::mode_offset;
  logic                        mclk = 0;
  logic                        rst = 1;
  logic                        cyc = 0;
  logic                        stb = 0;
  logic                        we = 0;
  logic [7:0]                  adr = 8'h00;
  logic [3:0]                  sel = 4'h0;
  logic [31:0]                 wdat = 32'h0;
  logic [31:0]                 rdat;
  logic                        ack;
  modulo_bitrev_pkg::agu_req_s xq = '0;
  modulo_bitrev_pkg::agu_req_s yq = '0;
  modulo_bitrev_pkg::agu_rsp_s xr;
  modulo_bitrev_pkg::agu_rsp_s yr;
  // Shadow of the register table; index is the byte address over four
  logic [15:0]                 rg [8];
  int                          num_errors = 0;
  int                          compares = 0;
  int                          cycles = 0;

  modulo_bitrev_address_gen dut
  (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .x_req(xq), .y_req(yq), .x_rsp(xr), .y_rsp(yr)
  );

  always #2.5 mclk = ~mclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; returns just after one
  task automatic bus(input logic w, input int k, input logic [3:0] s, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= 8'(k * 4);
    sel <= s;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      conclude();
    end
    q = rdat[15:0];
    cyc <= 0;
    stb <= 0;
    @(posedge mclk);
  endtask

  task automatic wr(input int k, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] q;
    bus(1, k, s, d, q);
    // Status and unmapped places ignore writes
    if (k < 6)
      rg[k] = {s[1] ? d[15:8] : rg[k][15:8], s[0] ? d[7:0] : rg[k][7:0]};
  endtask

  task automatic rd(input int k, input logic [15:0] e);
    logic [15:0] q;
    bus(0, k, 4'h3, 16'h0000, q);
    chk($sformatf("register %0d", k), e, q);
  endtask

  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
      rev[i] = v[15 - i];
  endfunction

  function automatic modulo_bitrev_pkg::agu_rsp_s model(input modulo_bitrev_pkg::agu_req_s r,
                                                        input logic x);
    modulo_bitrev_pkg::agu_rsp_s m;
    logic [15:0] stp, a, s, st, en;
    logic        inc, um, br, post;
    m = '0;
    st = x ? rg[1] : rg[3];
    en = x ? rg[2] : rg[4];
    stp = r.byte_access ? 16'h0001 : 16'h0002;
    post = r.mode inside {m_poi, m_pod};
    inc = ~(r.mode inside {m_pod, m_prd}) & ~(r.mode == m_off & r.offset[15]);
    a = r.mode == m_off ? r.pointer + r.offset : r.pointer;
    if (r.mode inside {m_poi, m_pri})
      a = a + stp;
    if (r.mode inside {m_pod, m_prd})
      a = a - stp;
    um = (x ? rg[0][15] : rg[0][14]) && r.wsel == (x ? rg[0][3:0] : rg[0][7:4])
         && r.wsel != 4'hf;
    if (um && inc && a > en)
      a = a - (en - st + 16'h0001);
    if (um && !inc && a < st)
      a = a + (en - st + 16'h0001);
    m.valid = r.valid;
    m.wsel = r.wsel;
    m.writeback = !(r.mode inside {m_ind, m_off});
    m.ea = post ? r.pointer : a;
    m.wb_value = a;
    m.modulo_used = um;
    br = x && r.is_write && !r.byte_access && (r.mode inside {m_poi, m_pri}) && rg[5][15]
         && rg[0][11:8] != 4'hf && r.wsel == rg[0][11:8];
    if (br)
    begin
      s = rev(rev(r.pointer) + rev({rg[5][14:0], 1'b0}));
      s[0] = 1'b0;
      m.ea = post ? {r.pointer[15:1], 1'b0} : s;
      m.wb_value = s;
      m.bitrev_used = 1'b1;
      m.modulo_used = 1'b0;
    end
    return m;
  endfunction

  // One address request on X (x=1) or Y, checked one cycle later
  task automatic go(input logic x, input logic w, input logic b,
                    input modulo_bitrev_pkg::addr_mode_e md, input logic [3:0] ws,
                    input logic [15:0] p, input logic [15:0] o);
    modulo_bitrev_pkg::agu_req_s r;
    modulo_bitrev_pkg::agu_rsp_s e, g;
    r = '{1'b1, w, b, md, ws, p, o};
    e = model(r, x);
    if (x)
      xq <= r;
    else
      yq <= r;
    @(posedge mclk);
    xq <= '0;
    yq <= '0;
    #1;
    g = x ? xr : yr;
    chk("valid", 16'(e.valid), 16'(g.valid));
    chk("ea", e.ea, g.ea);
    chk("writeback", 16'(e.writeback), 16'(g.writeback));
    chk("wsel", 16'(e.wsel), 16'(g.wsel));
    chk("bitrev_used", 16'(e.bitrev_used), 16'(g.bitrev_used));
    chk("modulo_used", 16'(e.modulo_used), 16'(g.modulo_used));
    if (e.writeback)
      chk("wb_value", e.wb_value, g.wb_value);
    @(posedge mclk);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    rg = '{16'h0fff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (4) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    for (int k = 0; k < 8; k++)
      rd(k, rg[k]);
    wr(7, 16'h1234, 4'h3);
    rd(7, 16'h0000);
    $display("test reset values done");
    wr(1, 16'h1000, 4'h3);
    wr(2, 16'h101f, 4'h3);
    wr(3, 16'h0800, 4'h3);
    wr(4, 16'h080f, 4'h3);
    wr(0, 16'hcf63, 4'h3);
    go(1, 0, 0, m_poi, 4'h3, 16'h101e, 16'h0);
    go(1, 0, 0, m_pri, 4'h3, 16'h101f, 16'h0);
    go(1, 1, 1, m_pod, 4'h3, 16'h1000, 16'h0);
    go(1, 0, 0, m_off, 4'h3, 16'h1018, 16'h0010);
    go(1, 0, 0, m_off, 4'h3, 16'h1004, 16'hfff0);
    go(1, 0, 0, m_ind, 4'h3, 16'h1010, 16'h0);
    go(1, 0, 0, m_poi, 4'h9, 16'h101e, 16'h0);
    go(0, 0, 0, m_prd, 4'h6, 16'h0800, 16'h0);
    go(0, 0, 0, m_pod, 4'h6, 16'h0800, 16'h0);
    go(0, 0, 0, m_pri, 4'h6, 16'h080e, 16'h0);
    $display("test modulo done");
    wr(1, 16'h2000, 4'h3);
    wr(2, 16'h203f, 4'h3);
    wr(5, 16'h8008, 4'h3);
    rd(5, 16'h8008);
    wr(0, 16'hc535, 4'h3);
    go(1, 1, 0, m_poi, 4'h5, 16'h2000, 16'h0);
    go(1, 1, 0, m_pri, 4'h5, 16'h2010, 16'h0);
    go(1, 1, 0, m_pri, 4'h5, 16'h203e, 16'h0);
    go(1, 1, 0, m_poi, 4'h5, 16'h2033, 16'h0);
    go(1, 0, 0, m_poi, 4'h5, 16'h2000, 16'h0);
    go(1, 1, 1, m_poi, 4'h5, 16'h2000, 16'h0);
    go(1, 1, 0, m_prd, 4'h5, 16'h2004, 16'h0);
    go(1, 1, 0, m_poi, 4'h6, 16'h2000, 16'h0);
    go(0, 1, 0, m_poi, 4'h5, 16'h2000, 16'h0);
    wr(0, 16'hcf35, 4'h3);
    go(1, 1, 0, m_poi, 4'h5, 16'h2000, 16'h0);
    wr(0, 16'hc535, 4'h3);
    wr(5, 16'h0008, 4'h2);
    rd(5, 16'h0008);
    go(1, 1, 0, m_poi, 4'h5, 16'h2000, 16'h0);
    rd(6, 16'h6000);
    $display("test bit reverse done");
    conclude();
  end
endmodule
